// ===== rtl/gpio_port.sv
/*
  General purpose port with pin configuration, glitch filters and pin
  interrupts, reached over an AXI4-Lite slave.
  Assumes pins are asynchronous, peripherals run on core_clk_i, and the
  pad drives the wire from pin_out_o when pin_oe_n_o is low.
*/
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module gpio_port
  import gpio_pkg::*;
#(
  parameter int PINS = DEF_PINS,
  parameter int FILT_PINS = DEF_FILT_PINS,
  parameter int SLOTS = DEF_SLOTS,
  parameter int FUNCS = DEF_FUNCS
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [PINS-1:0] pin_in_i,
  output logic [PINS-1:0] pin_out_o,
  output logic [PINS-1:0] pin_oe_n_o,
  output logic [PINS-1:0] pull_up_o,
  output logic [PINS-1:0] pull_down_o,
  output logic [PINS-1:0] repeater_o,
  output logic [PINS-1:0] slew_slow_o,
  input wire logic [FUNCS-1:0][PINS-1:0] periph_out_i,
  input wire logic [FUNCS-1:0][PINS-1:0] periph_oe_i,
  output logic [PINS-1:0] periph_in_o,
  output logic [SLOTS-1:0] wake_o,
  output logic irq_o
);
  localparam int SELW = $clog2(FILT_PINS);

  // ****************************************
  // Address decode helpers
  // ****************************************
  function automatic logic is_cfg(input logic [11:0] a);
    return a >= OFS_CFG_BASE && a < OFS_CFG_BASE + 12'(4 * PINS);
  endfunction
  function automatic logic is_slot(input logic [11:0] a);
    return a >= OFS_SLOT_BASE && a < OFS_SLOT_BASE + 12'(4 * SLOTS);
  endfunction

  // ****************************************
  // Write channel
  // ****************************************
  logic aw_held_q, w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  logic wr_hit;
  assign wr_hit = awaddr_q == OFS_DATA || awaddr_q == OFS_SET || awaddr_q == OFS_CLR
    || awaddr_q == OFS_DIR || awaddr_q == OFS_OUT || awaddr_q == OFS_INT_STAT
    || awaddr_q == OFS_INT_MASK || is_slot(awaddr_q) || is_cfg(awaddr_q);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic [31:0] wmask;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{wstrb_q[b]}};
    end
  end

  // ****************************************
  // Port data and direction
  // ****************************************
  logic [PINS-1:0] out_q, dir_q;
  logic [PINS-1:0] wm;
  assign wm = wmask[PINS-1:0];

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      out_q <= '0;
    end else if (wr_go && (awaddr_q == OFS_DATA || awaddr_q == OFS_OUT)) begin
      out_q <= (out_q & ~wm) | (wdata_q[PINS-1:0] & wm);
    end else if (wr_go && awaddr_q == OFS_SET) begin
      out_q <= out_q | (wdata_q[PINS-1:0] & wm);
    end else if (wr_go && awaddr_q == OFS_CLR) begin
      out_q <= out_q & ~(wdata_q[PINS-1:0] & wm);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      dir_q <= '0;
    end else if (wr_go && awaddr_q == OFS_DIR) begin
      dir_q <= (dir_q & ~wm) | (wdata_q[PINS-1:0] & wm);
    end
  end

  // ****************************************
  // Pin configuration block
  // ****************************************
  logic [CFG_W-1:0] cfg_q [PINS];
  logic [PINS-1:0] sync1_q, sync2_q, filt;
  logic [PINS-1:0] drv_val, drv_en;

  generate
    for (genvar p = 0; p < PINS; p++) begin : g_pin
      localparam logic [11:0] CFG_ADR = OFS_CFG_BASE + 12'(4 * p);
      localparam bit IS_OD = (p == OD_PIN_A) || (p == OD_PIN_B);
      logic [1:0] fsel;
      logic od;
      assign fsel = cfg_q[p][CFG_FUNC_LSB +: 2];
      assign od = cfg_q[p][CFG_OD_BIT] || IS_OD;

      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          cfg_q[p] <= IS_OD ? CFG_OD_RST : CFG_RST;
        end else if (wr_go && awaddr_q == CFG_ADR && wstrb_q[0]) begin
          cfg_q[p] <= wdata_q[CFG_W-1:0];
        end
      end

      always_comb begin
        if (fsel == 2'h0 || int'(fsel) > FUNCS) begin
          drv_val[p] = out_q[p];
          drv_en[p] = dir_q[p];
        end else begin
          drv_val[p] = periph_out_i[int'(fsel) - 1][p];
          drv_en[p] = periph_oe_i[int'(fsel) - 1][p];
        end
      end

      // Pads are registered so a bus write and a mux change reach the pin together.
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          pin_out_o[p] <= 1'b0;
          pin_oe_n_o[p] <= 1'b1;
        end else begin
          pin_out_o[p] <= drv_val[p];
          pin_oe_n_o[p] <= !(drv_en[p] && !(od && drv_val[p]));
        end
      end

      assign pull_up_o[p] = pull_mode_e'(cfg_q[p][CFG_PULL_LSB +: 2]) == PULL_UP;
      assign pull_down_o[p] = pull_mode_e'(cfg_q[p][CFG_PULL_LSB +: 2]) == PULL_DOWN;
      assign repeater_o[p] = pull_mode_e'(cfg_q[p][CFG_PULL_LSB +: 2]) == PULL_REPEAT;
      assign slew_slow_o[p] = cfg_q[p][CFG_SLEW_BIT];

      if (p < FILT_PINS) begin : g_filt
        glitch_filter #(.CYC(IS_OD ? FILT_OD_CYC : FILT_CYC)) u_filt (
          .core_clk_i(core_clk_i),
          .reset_i(reset_i),
          .en_i(cfg_q[p][CFG_FILT_BIT]),
          .d_i(sync2_q[p]),
          .q_o(filt[p])
        );
      end else begin : g_raw
        assign filt[p] = sync2_q[p];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= pin_in_i;
      sync2_q <= sync1_q;
    end
  end

  assign periph_in_o = filt;

  // ****************************************
  // Pin interrupts
  // ****************************************
  logic [SLOT_W-1:0] slot_q [SLOTS];
  logic [SLOTS-1:0] stat, mask_q;

  generate
    for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      localparam logic [11:0] SLOT_ADR = OFS_SLOT_BASE + 12'(4 * s);
      logic [SELW-1:0] psel;
      assign psel = slot_q[s][SLOT_PIN_LSB +: SELW];

      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          slot_q[s] <= SLOT_RST;
        end else if (wr_go && awaddr_q == SLOT_ADR && wstrb_q[0]) begin
          slot_q[s] <= wdata_q[SLOT_W-1:0];
        end
      end

      // The source is read from the pin level whatever function the pin serves.
      pin_irq_slot u_slot (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .lvl_i(filt[psel]),
        .mode_i(slot_q[s][SLOT_MODE_LSB +: 2]),
        .pol_i(slot_q[s][SLOT_POL_BIT]),
        .clr_i(wr_go && awaddr_q == OFS_INT_STAT && wstrb_q[0] && wdata_q[s]),
        .stat_o(stat[s]),
        .wake_o(wake_o[s])
      );
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mask_q <= '0;
    end else if (wr_go && awaddr_q == OFS_INT_MASK && wstrb_q[0]) begin
      mask_q <= wdata_q[SLOTS-1:0];
    end
  end

  assign irq_o = |(stat & mask_q);

  // ****************************************
  // Read channel
  // ****************************************
  logic [31:0] rd_val;
  logic rd_hit;
  logic [11:0] ra;
  assign ra = {s_axi_araddr[11:2], 2'b00};
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (ra == OFS_DATA) begin
      rd_val[PINS-1:0] = sync2_q;
    end else if (ra == OFS_SET || ra == OFS_CLR || ra == OFS_OUT) begin
      rd_val[PINS-1:0] = out_q;
    end else if (ra == OFS_DIR) begin
      rd_val[PINS-1:0] = dir_q;
    end else if (ra == OFS_INT_STAT) begin
      rd_val[SLOTS-1:0] = stat;
    end else if (ra == OFS_INT_MASK) begin
      rd_val[SLOTS-1:0] = mask_q;
    end else if (is_slot(ra)) begin
      rd_val[SLOT_W-1:0] = slot_q[ra[2 +: $clog2(SLOTS)]];
    end else if (is_cfg(ra)) begin
      rd_val[CFG_W-1:0] = cfg_q[ra[2 +: $clog2(PINS)]];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  set_keeps_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_go && awaddr_q == OFS_SET |=> out_q == ($past(out_q) | ($past(wdata_q[PINS-1:0]) & $past(wm))))
    else $error("set write disturbed unselected bits");
  clr_keeps_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_go && awaddr_q == OFS_CLR |=> out_q == ($past(out_q) & ~($past(wdata_q[PINS-1:0]) & $past(wm))))
    else $error("clear write disturbed unselected bits");
  full_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_go && awaddr_q == OFS_DATA && wstrb_q == 4'hf |=> out_q == $past(wdata_q[PINS-1:0]))
    else $error("full write did not load every bit");
  write_resp_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_go |=> s_axi_bvalid ##0 (s_axi_bresp == (($past(wr_hit)) ? RESP_OKAY : RESP_DECERR)))
    else $error("write response late or wrong");
  read_resp_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata == $past(rd_val))
    else $error("read answer late or wrong");
  reset_input_a: assert property (@(posedge core_clk_i)
    $fell(reset_i) |-> pin_oe_n_o == '1 && pull_up_o[OD_PIN_A] == 1'b0 && pull_up_o[0] == 1'b1)
    else $error("pins not inputs with pull-up after reset");
  port_drive_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cfg_q[0][1:0] == 2'h0 && !cfg_q[0][CFG_OD_BIT] && $stable(cfg_q[0]) |=> pin_oe_n_o[0] == !$past(dir_q[0]))
    else $error("direction register does not steer the pin");
  open_drain_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cfg_q[1][CFG_OD_BIT] && drv_val[1] |=> pin_oe_n_o[1])
    else $error("open-drain pin drove high");
  irq_level_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    irq_o |-> (stat & mask_q) != '0)
    else $error("interrupt output mismatch");

  set_write_c: cover property (@(posedge core_clk_i) wr_go && awaddr_q == OFS_SET);
  irq_raise_c: cover property (@(posedge core_clk_i) $rose(irq_o));
  periph_pin_c: cover property (@(posedge core_clk_i) cfg_q[5][1:0] == 2'h1 && !pin_oe_n_o[5]);
  bad_addr_c: cover property (@(posedge core_clk_i) s_axi_rvalid && s_axi_rresp == RESP_DECERR);
endmodule
`default_nettype wire

// ===== rtl/gpio_pkg.sv
/*
  Shared constants for the general purpose port: register offsets, field
  positions, reset values, trigger and pull modes, and filter timing.
  Assumes a 250 MHz core clock and a 12-bit byte address inside the slave.
*/
`default_nettype none
package gpio_pkg;

  // ****************************************
  // Clock and filter timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int FILT_NS = 10;
  localparam int FILT_OD_NS = 50;
  // Pulses up to the figure are suppressed, so the count rounds up.
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_OD_CYC = (FILT_OD_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int DEF_PINS = 32;
  localparam int DEF_FILT_PINS = 16;
  localparam int DEF_SLOTS = 8;
  localparam int DEF_FUNCS = 3;
  localparam int OD_PIN_A = 2;
  localparam int OD_PIN_B = 3;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_SET = 12'h004;
  localparam logic [11:0] OFS_CLR = 12'h008;
  localparam logic [11:0] OFS_DIR = 12'h00c;
  localparam logic [11:0] OFS_OUT = 12'h010;
  localparam logic [11:0] OFS_INT_STAT = 12'h020;
  localparam logic [11:0] OFS_INT_MASK = 12'h024;
  localparam logic [11:0] OFS_SLOT_BASE = 12'h040;
  localparam logic [11:0] OFS_CFG_BASE = 12'h100;

  // ****************************************
  // Fields
  // ****************************************
  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_PULL_LSB = 2;
  localparam int CFG_OD_BIT = 4;
  localparam int CFG_SLEW_BIT = 5;
  localparam int CFG_FILT_BIT = 6;
  localparam int CFG_W = 7;
  localparam int SLOT_PIN_LSB = 0;
  localparam int SLOT_MODE_LSB = 5;
  localparam int SLOT_POL_BIT = 7;
  localparam int SLOT_W = 8;

  typedef enum logic [1:0] {PULL_NONE, PULL_DOWN, PULL_UP, PULL_REPEAT} pull_mode_e;
  typedef enum logic [1:0] {TRIG_LEVEL, TRIG_RISE, TRIG_FALL, TRIG_BOTH} trig_mode_e;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CFG_W-1:0] CFG_RST = 7'h08;
  localparam logic [CFG_W-1:0] CFG_OD_RST = 7'h00;
  localparam logic [SLOT_W-1:0] SLOT_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage
`default_nettype wire

// ===== rtl/glitch_filter.sv
/*
  One-pin input glitch filter with a bypass.
  Assumes d_i is already synchronised to core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module glitch_filter #(
  parameter int CYC = 3
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic en_i,
  input wire logic d_i,
  output logic q_o
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] CYC_V = CW'(CYC);
  logic [CW-1:0] cnt_q;
  logic lvl_q;

  // A new level passes only after it has held for more than CYC samples.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_q <= '0;
      lvl_q <= 1'b1;
    end else if (!en_i || d_i == lvl_q) begin
      cnt_q <= '0;
      lvl_q <= d_i;
    end else if (cnt_q == CYC_V) begin
      cnt_q <= '0;
      lvl_q <= d_i;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign q_o = lvl_q;

  short_pulse_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $past(en_i) && $changed(lvl_q) |-> $past(d_i) == lvl_q && $past(cnt_q) == CYC_V)
    else $error("filter passed a level that had not held long enough");
endmodule
`default_nettype wire

// ===== rtl/pin_irq_slot.sv
/*
  One pin interrupt slot: level or edge detection with a pending flag.
  Assumes lvl_i is a synchronised, optionally filtered pin level.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_irq_slot
  import gpio_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic lvl_i,
  input wire logic [1:0] mode_i,
  input wire logic pol_i,
  input wire logic clr_i,
  output logic stat_o,
  output logic wake_o
);
  logic prev_q;
  logic pend_q;
  logic rise, fall, edge_hit, lvl_hit;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      // Starts at the synchronisers' reset level, so no false edge follows reset.
      prev_q <= 1'b1;
    end else begin
      prev_q <= lvl_i;
    end
  end

  always_comb begin
    rise = lvl_i && !prev_q;
    fall = !lvl_i && prev_q;
    case (trig_mode_e'(mode_i))
      TRIG_RISE: edge_hit = rise;
      TRIG_FALL: edge_hit = fall;
      TRIG_BOTH: edge_hit = rise || fall;
      default: edge_hit = 1'b0;
    endcase
    lvl_hit = (trig_mode_e'(mode_i) == TRIG_LEVEL) && (lvl_i == pol_i);
  end

  // An edge in the clearing cycle keeps the flag set.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pend_q <= 1'b0;
    end else if (edge_hit) begin
      pend_q <= 1'b1;
    end else if (clr_i || trig_mode_e'(mode_i) == TRIG_LEVEL) begin
      pend_q <= 1'b0;
    end
  end

  assign stat_o = (pend_q && trig_mode_e'(mode_i) != TRIG_LEVEL) || lvl_hit;
  assign wake_o = edge_hit || lvl_hit;

  edge_sticky_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    edge_hit |=> pend_q)
    else $error("edge did not latch the pending flag");
  level_follow_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_i == 2'h0 |-> stat_o == (lvl_i == pol_i))
    else $error("level status does not follow the pin");
endmodule
`default_nettype wire

// ===== verif/pin_partner.sv
/*
  Far side of the port pins: resolves each wire from the pad drive, an
  external driver of the bench and the pull settings.
  Assumes the pad drives the wire while its output enable is low.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_partner #(
  parameter int PINS = 32
) (
  input wire logic core_clk_i,
  input wire logic [PINS-1:0] pad_out_i,
  input wire logic [PINS-1:0] pad_oe_n_i,
  input wire logic [PINS-1:0] pull_up_i,
  input wire logic [PINS-1:0] pull_down_i,
  input wire logic [PINS-1:0] repeater_i,
  input wire logic [PINS-1:0] ext_val_i,
  input wire logic [PINS-1:0] ext_en_i,
  output logic [PINS-1:0] wire_o
);
  // ****************************************
  // Wire resolution
  // ****************************************
  logic [PINS-1:0] last_q = '0;
  // A line nobody drives, pulls or holds with the repeater shows the inverse of its last level, so a
  // floating pin is never read as a steady value.
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (!pad_oe_n_i[i]) begin
        wire_o[i] = pad_out_i[i];
      end else if (ext_en_i[i]) begin
        wire_o[i] = ext_val_i[i];
      end else if (pull_up_i[i]) begin
        wire_o[i] = 1'b1;
      end else if (pull_down_i[i]) begin
        wire_o[i] = 1'b0;
      end else if (repeater_i[i]) begin
        wire_o[i] = last_q[i];
      end else begin
        wire_o[i] = ~last_q[i];
      end
    end
  end
  always @(posedge core_clk_i) begin
    last_q <= wire_o;
  end
endmodule
`default_nettype wire

// ===== verif/gpio_port_with_pin_interrupts_test.sv
/*
  Self-checking bench for the port: bus tasks and one task per scenario.
  Assumes the default geometry and pin_partner on the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_port_with_pin_interrupts_test
  import gpio_pkg::*;
;
  // ****************************************
  // Bench signals
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, pin_in, pin_out, oe_n, pu, pd, rep, slew, sense, d;
  logic [7:0] wake;
  logic [2:0][31:0] p_out = '0;
  logic [2:0][31:0] p_oe = '0;
  logic [31:0] ext_val = '0;
  logic [31:0] ext_en = '0;
  int n;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  gpio_port dut_u (.core_clk_i(clk), .reset_i(rst), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_n_o(oe_n), .pull_up_o(pu), .pull_down_o(pd), .repeater_o(rep),
    .slew_slow_o(slew), .periph_out_i(p_out), .periph_oe_i(p_oe), .periph_in_o(sense),
    .wake_o(wake), .irq_o(irq));

  pin_partner partner_u (.core_clk_i(clk), .pad_out_i(pin_out), .pad_oe_n_i(oe_n), .pull_up_i(pu),
    .pull_down_i(pd), .repeater_i(rep), .ext_val_i(ext_val), .ext_en_i(ext_en), .wire_o(pin_in));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic give_verdict;
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wq(input logic [11:0] a, input logic [31:0] v);
    wr(a, v);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    forever begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic pin1(input logic v, input int k);
    @(posedge clk);
    ext_val[1] <= v;
    repeat (k) @(posedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk("pull_up", 32'hffff_fff3, pu);
    chk("oe_n", 32'hffff_ffff, oe_n);
    chk("pull_down", 32'h0, pd);
    rd(OFS_DIR);
    chk("dir", 32'h0, d);
  endtask

  task automatic t_out;
    wq(OFS_DIR, 32'hffff_ffff);
    wq(OFS_DATA, 32'ha5a5_5a5a);
    repeat (3) @(posedge clk);
    chk("pin_out", 32'ha5a5_5a5a, pin_out);
    chk("oe_n", 32'h0000_0008, oe_n);
    wq(OFS_SET, 32'h0000_00f0);
    wq(OFS_CLR, 32'h0f00_0002);
    repeat (3) @(posedge clk);
    chk("pin_out", 32'ha0a5_5af8, pin_out);
    rd(OFS_CLR);
    chk("out_reg", 32'ha0a5_5af8, d);
    rd(OFS_DATA);
    chk("data", 32'ha0a5_5af0, d & 32'hffff_fff3);
    wq(OFS_DIR, 32'h0);
  endtask

  task automatic t_in;
    ext_en <= 32'hffff_0002;
    ext_val <= 32'h5a3c_0000;
    repeat (4) @(posedge clk);
    rd(OFS_DATA);
    chk("data_in", 32'h5a3c_0000, d & 32'hffff_0000);
  endtask

  task automatic t_cfg;
    // Routing is set up before the peripheral drives the pin.
    wq(OFS_CFG_BASE + 12'h014, 32'h0000_0025);
    p_out[0][5] <= 1'b1;
    p_oe[0][5] <= 1'b1;
    wq(OFS_CFG_BASE + 12'h018, 32'h0000_0018);
    wq(OFS_CFG_BASE + 12'h01c, 32'h0000_000c);
    wq(OFS_DIR, 32'h0000_0040);
    wq(OFS_SET, 32'h0000_0040);
    repeat (4) @(posedge clk);
    chk("pin5", 32'h2b, {26'h0, pin_out[5], oe_n[5], pd[5], pu[5], slew[5], sense[5]});
    chk("pin6_7", 32'h7, {29'h0, oe_n[6], pu[6], rep[7]});
    wq(OFS_CLR, 32'h0000_0040);
    repeat (3) @(posedge clk);
    chk("pin6_low", 32'h0, {31'h0, oe_n[6]});
  endtask

  task automatic t_irq;
    for (int m = 1; m < 4; m++) begin
      wq(OFS_SLOT_BASE, 32'((m << 5) | 1));
      wq(OFS_INT_MASK, 32'h1);
      wq(OFS_INT_STAT, 32'h1);
      chk("irq_idle", 32'h0, {31'h0, irq});
      pin1(1'b1, 6);
      chk("irq_rise", {31'h0, m != 2}, {31'h0, irq});
      pin1(1'b0, 6);
      chk("irq_fall", 32'h1, {31'h0, irq});
      wq(OFS_INT_STAT, 32'h1);
      chk("irq_clr", 32'h0, {31'h0, irq});
    end
    wq(OFS_INT_MASK, 32'h0);
    pin1(1'b1, 6);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rd(OFS_INT_STAT);
    chk("stat", 32'h1, d);
    pin1(1'b0, 2);
    wq(OFS_INT_STAT, 32'h1);
    wq(OFS_INT_MASK, 32'h1);
    wq(OFS_SLOT_BASE, 32'h0000_0081);
    chk("lvl_low", 32'h0, {31'h0, irq});
    pin1(1'b1, 6);
    wq(OFS_INT_STAT, 32'h1);
    chk("lvl_high", 32'h1, {31'h0, irq});
    chk("wake", 32'h1, {31'h0, wake[0]});
    pin1(1'b0, 6);
    chk("lvl_gone", 32'h0, {31'h0, irq});
  endtask

  task automatic t_filt;
    wq(OFS_CFG_BASE + 12'h004, 32'h0000_0048);
    wq(OFS_SLOT_BASE, 32'h0000_0021);
    wq(OFS_INT_STAT, 32'h1);
    pin1(1'b1, FILT_CYC - 1);
    pin1(1'b0, 10);
    chk("glitch", 32'h0, {31'h0, irq});
    pin1(1'b1, FILT_CYC + 8);
    chk("filtered", 32'h1, {31'h0, irq});
  endtask

  task automatic t_bad;
    rd(12'h014);
    chk("rresp", {30'h0, RESP_DECERR}, {30'h0, r});
    chk("rdata", 32'h0, d);
    chk("latency", 32'h2, 32'(n));
    wr(12'h014, 32'hffff_ffff);
    chk("bresp", {30'h0, RESP_DECERR}, {30'h0, r});
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_out();
    t_in();
    t_cfg();
    t_irq();
    t_filt();
    t_bad();
    give_verdict();
  end
endmodule
`default_nettype wire
